// [common/seq_exit_pkg.sv]
/*
 * Shared constants and types for the receive-exit sequencer and its timers.
 * Assumes a 100 MHz system clock and an APB master with 32-bit data.
 */
package seq_exit_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 10;

    // Timer tick periods in ns, and their lengths in clock cycles
    localparam int TICK_FINE_NS = 64000;
    localparam int TICK_MID_NS = 4100000;
    localparam int TICK_COARSE_NS = 262000000;
    localparam int TICK_FINE_CYC = TICK_FINE_NS / CLK_PERIOD_NS;
    localparam int TICK_MID_CYC = TICK_MID_NS / CLK_PERIOD_NS;
    localparam int TICK_COARSE_CYC = TICK_COARSE_NS / CLK_PERIOD_NS;
    localparam int PRESCALE_W = 25;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_EXIT_CFG = 8'h37;
    localparam logic [7:0] IDX_TICK_SEL = 8'h38;
    localparam logic [7:0] IDX_T1_MULT = 8'h39;
    localparam logic [7:0] IDX_T2_MULT = 8'h3a;
    localparam logic [7:0] IDX_CONTROL = 8'h40;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h41;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h42;
    localparam logic [7:0] IDX_SEQ_STATE = 8'h43;

    // Reset values
    localparam logic [7:0] RST_EXIT_CFG = 8'h00;
    localparam logic [7:0] RST_TICK_SEL = 8'h00;
    localparam logic [7:0] RST_T1_MULT = 8'hf5;
    localparam logic [7:0] RST_T2_MULT = 8'h20;
    localparam logic [4:0] RST_CONTROL = 5'h00;

    // Tick select encoding
    localparam logic [1:0] TICK_OFF = 2'h0;
    localparam logic [1:0] TICK_FINE = 2'h1;
    localparam logic [1:0] TICK_MID = 2'h2;

    // Receive-exit select codes
    localparam logic [2:0] RX_PAYLOAD_STORE = 3'h1;
    localparam logic [2:0] RX_PAYLOAD_LOWPWR = 3'h2;
    localparam logic [2:0] RX_CHECKSUM_STORE = 3'h3;
    localparam logic [2:0] RX_LEVEL_HALT = 3'h4;
    localparam logic [2:0] RX_SYNC_HALT = 3'h5;
    localparam logic [2:0] RX_PREAMBLE_HALT = 3'h6;

    // Timeout-exit select codes
    localparam logic [1:0] TO_RELAUNCH = 2'h0;
    localparam logic [1:0] TO_TRANSMIT = 2'h1;
    localparam logic [1:0] TO_LOWPWR = 2'h2;

    // Packet-stored exit select codes
    localparam logic [2:0] PS_HALT = 3'h0;
    localparam logic [2:0] PS_TX_EMPTY = 3'h1;
    localparam logic [2:0] PS_LOWPWR = 3'h2;
    localparam logic [2:0] PS_RX_SYNTH = 3'h3;
    localparam logic [2:0] PS_RX_DIRECT = 3'h4;

    // Interrupt status bit positions of the timers; status_r puts the halt at bit 2, the receive timeout at bit 3
    localparam int IRQ_T1 = 0;
    localparam int IRQ_T2 = 1;
    localparam int IRQ_RX_TIMEOUT = 2;
    localparam int IRQ_HALTED = 3;
    localparam int IRQ_W = 4;

    // Sequencer states, Gray along halted-receive-stored-synth-transmit-idle
    typedef enum logic [2:0] {
        ST_HALTED = 3'h0,
        ST_RECEIVE = 3'h1,
        ST_PACKET_STORED = 3'h3,
        ST_FREQ_SYNTH = 3'h2,
        ST_TRANSMIT = 3'h6,
        ST_IDLE = 3'h7,
        ST_RELAUNCH = 3'h5
    } seq_state_t;

    // Receiver and buffer event pulses
    typedef struct packed {
        logic payload_complete_flag;
        logic checksum_good_flag;
        logic checksum_bad;
        logic signal_level_flag;
        logic sync_word_match_flag;
        logic preamble_seen_flag;
        logic signal_level_timeout;
        logic preamble_timeout;
        logic sync_timeout;
        logic buffer_empty_flag;
        logic packet_sent;
    } rx_events_t;

endpackage : seq_exit_pkg

// [hw/seq_exit_top.sv]
/*
 * Receive-exit sequencer with two interval timers, APB register slave and
 * a masked interrupt output.
 * Assumes event inputs are one-cycle pulses synchronous to i_sys_clk and an
 * APB master that holds each request until it samples pready high.
 */
// Behaviour
// R1: Receive-exit select 001 stores the packet and 010 takes the low-power choice on payload complete; 000 and 111 do nothing.
// R2: Receive-exit select 011 stores the packet when the checksum-good flag rises.
// R3: Receive-exit select 100 halts the sequencer on the signal-level flag.
// R4: Receive-exit select 101 halts the sequencer on a sync-word match.
// R5: Receive-exit select 110 halts the sequencer when a preamble is seen.
// R6: With checksum on and autoflush off, a corrupted payload takes the timeout path instead of being stored.
// R7: Timeout-exit select 00 relaunches the receiver, 01 transmits, 10 takes the low-power choice, 11 halts.
// R8: Any of the three receive timeouts is a timeout event, and so is payload complete under receive-exit 011.
// R9: Packet-stored exit 000 halts, 001 transmits once the buffer is empty, 010 takes the low-power choice.
// R10: Packet-stored exit 011 returns to receive through synthesis if the frequency changed, 100 returns directly.
// R11: First timer tick select 00 disables it, 01 is 64 us, 10 is 4.1 ms, 11 is 262 ms.
// R12: Second timer tick select at bits 1-0 uses the same encoding as the first.
// R13: First timer multiplier is read-write and resets to 0xf5.
// R14: Second timer multiplier is read-write and resets to 0x20.
// R15: The low-power choice halts when its select bit is 0 and goes idle when it is 1.
// R16: On the first timer event in idle, go to transmit if idle-exit is 0, else to receive.
// R17: An enabled timer fires when tick times multiplier has elapsed; a disabled one never fires.
`timescale 1ns/1ps
`default_nettype none

// Interval timer: prescaler to the selected tick, then counts ticks
module interval_timer
    import seq_exit_pkg::*;
#(
    parameter int FINE_CYC = TICK_FINE_CYC,
    parameter int MID_CYC = TICK_MID_CYC,
    parameter int COARSE_CYC = TICK_COARSE_CYC
) (
    input wire logic i_sys_clk,         // System clock
    input wire logic i_rstn,            // Async reset, active low
    input wire logic [1:0] i_tick_sel,  // Tick select
    input wire logic [7:0] i_mult,      // Multiplier
    output logic o_fire                 // One-cycle pulse at expiry
);
    logic [PRESCALE_W-1:0] pre_r;
    logic [PRESCALE_W-1:0] pre_last;
    logic [7:0] ticks_r;
    logic [1:0] sel_q_r;
    logic tick;
    logic expire;

    // Last prescaler value for the selected tick
    always_comb begin
        unique case (i_tick_sel)
            TICK_FINE: pre_last = PRESCALE_W'(FINE_CYC - 1);
            TICK_MID: pre_last = PRESCALE_W'(MID_CYC - 1);
            default: pre_last = PRESCALE_W'(COARSE_CYC - 1);
        endcase
    end

    assign tick = (i_tick_sel != TICK_OFF) && (pre_r == pre_last);
    // A multiplier of zero behaves as one tick
    assign expire = tick && ((ticks_r + 8'h01) >= i_mult); // R17

    // Restart whenever disabled or the tick select changes
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_r <= '0;
            ticks_r <= 8'h00;
            sel_q_r <= TICK_OFF;
        end else begin
            sel_q_r <= i_tick_sel;
            if (i_tick_sel == TICK_OFF || i_tick_sel != sel_q_r) begin
                pre_r <= '0; // R11
                ticks_r <= 8'h00;
            end else if (tick) begin
                pre_r <= '0;
                ticks_r <= expire ? 8'h00 : ticks_r + 8'h01;
            end else begin
                pre_r <= pre_r + PRESCALE_W'(1);
            end
        end
    end

    // Registered expiry pulse
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_fire <= 1'b0;
        end else begin
            o_fire <= expire && (i_tick_sel == sel_q_r); // R17
        end
    end
endmodule : interval_timer

module seq_exit_top
    import seq_exit_pkg::*;
#(
    parameter int FINE_CYC = TICK_FINE_CYC,
    parameter int MID_CYC = TICK_MID_CYC,
    parameter int COARSE_CYC = TICK_COARSE_CYC
) (
    input wire logic i_sys_clk,         // System clock, 100 MHz
    input wire logic i_rstn,            // Async reset, active low
    input wire logic i_psel,            // APB select
    input wire logic i_penable,         // APB enable
    input wire logic i_pwrite,          // APB direction
    input wire logic [11:0] i_paddr,    // APB byte address
    input wire logic [31:0] i_pwdata,   // APB write data
    output logic [31:0] o_prdata,       // APB read data
    output logic o_pready,              // APB ready
    output logic o_pslverr,             // APB error on unmapped address
    input wire rx_events_t i_ev,        // Event pulses
    input wire logic i_freq_changed,    // Frequency changed since receive
    output seq_state_t o_state,         // Sequencer state
    output logic o_relaunch,            // Receiver relaunch pulse
    output logic o_irq                  // Interrupt, active high level
);
    logic [7:0] exit_cfg_r;
    logic [3:0] tick_sel_r;
    logic [7:0] t1_mult_r;
    logic [7:0] t2_mult_r;
    logic [4:0] control_r;
    logic [IRQ_W-1:0] status_r;
    logic [IRQ_W-1:0] mask_r;
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic t1_fire;
    logic t2_fire;
    logic timeout_ev;
    logic start_req;
    logic bus_access;
    logic bus_done;
    logic addr_ok;
    logic [7:0] idx;
    logic [31:0] rd_data;

    // Field aliases
    logic [2:0] receive_exit_select;
    logic [1:0] timeout_exit_select;
    logic [2:0] packet_stored_exit_select;
    logic low_power_select;
    logic idle_exit_select;
    logic checksum_enable;
    logic checksum_fail_autoflush;
    seq_state_t low_power_choice;
    seq_state_t timeout_target;

    assign receive_exit_select = exit_cfg_r[7:5];
    assign timeout_exit_select = exit_cfg_r[4:3];
    assign packet_stored_exit_select = exit_cfg_r[2:0];
    assign low_power_select = control_r[0];
    assign idle_exit_select = control_r[1];
    assign checksum_enable = control_r[2];
    assign checksum_fail_autoflush = control_r[3];

    // Bus decode: word-aligned index, access completes with pready high
    assign idx = i_paddr[9:2];
    assign bus_access = i_psel && i_penable && !o_pready;
    assign bus_done = i_psel && i_penable && o_pready;
    assign start_req = bus_done && i_pwrite && addr_ok
        && (idx == IDX_CONTROL) && i_pwdata[4];

    // Address map and read mux
    always_comb begin
        addr_ok = 1'b1;
        rd_data = 32'h0000_0000;
        if (i_paddr[11:10] != 2'h0 || i_paddr[1:0] != 2'h0) begin
            addr_ok = 1'b0;
        end else begin
            unique case (idx)
                IDX_EXIT_CFG: rd_data[7:0] = exit_cfg_r;
                IDX_TICK_SEL: rd_data[3:0] = tick_sel_r;
                IDX_T1_MULT: rd_data[7:0] = t1_mult_r;
                IDX_T2_MULT: rd_data[7:0] = t2_mult_r;
                IDX_CONTROL: rd_data[3:0] = control_r[3:0];
                IDX_IRQ_STATUS: rd_data[IRQ_W-1:0] = status_r;
                IDX_IRQ_MASK: rd_data[IRQ_W-1:0] = mask_r;
                IDX_SEQ_STATE: rd_data[2:0] = state_r;
                default: addr_ok = 1'b0;
            endcase
        end
    end

    // APB handshake: one wait state, read data captured before ready
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= bus_access;
            if (bus_access) begin
                o_prdata <= i_pwrite ? 32'h0000_0000 : rd_data;
                o_pslverr <= !addr_ok;
            end else if (bus_done) begin
                o_pslverr <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            exit_cfg_r <= RST_EXIT_CFG;
            tick_sel_r <= RST_TICK_SEL[3:0];
            t1_mult_r <= RST_T1_MULT; // R13
            t2_mult_r <= RST_T2_MULT; // R14
            control_r <= RST_CONTROL;
            mask_r <= '0;
        end else if (bus_done && i_pwrite && addr_ok) begin
            unique case (idx)
                IDX_EXIT_CFG: exit_cfg_r <= i_pwdata[7:0];
                IDX_TICK_SEL: tick_sel_r <= i_pwdata[3:0]; // R11 R12
                IDX_T1_MULT: t1_mult_r <= i_pwdata[7:0]; // R13
                IDX_T2_MULT: t2_mult_r <= i_pwdata[7:0]; // R14
                IDX_CONTROL: control_r <= {1'b0, i_pwdata[3:0]};
                IDX_IRQ_MASK: mask_r <= i_pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Timers
    interval_timer #(
        .FINE_CYC(FINE_CYC),
        .MID_CYC(MID_CYC),
        .COARSE_CYC(COARSE_CYC)
    ) u_first_timer (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_tick_sel(tick_sel_r[3:2]), // R11
        .i_mult(t1_mult_r),
        .o_fire(t1_fire)
    );

    interval_timer #(
        .FINE_CYC(FINE_CYC),
        .MID_CYC(MID_CYC),
        .COARSE_CYC(COARSE_CYC)
    ) u_second_timer (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_tick_sel(tick_sel_r[1:0]), // R12
        .i_mult(t2_mult_r),
        .o_fire(t2_fire)
    );

    // Receive timeout event
    assign timeout_ev = i_ev.signal_level_timeout || i_ev.preamble_timeout
        || i_ev.sync_timeout; // R8

    // Low-power choice target
    assign low_power_choice = low_power_select ? ST_IDLE : ST_HALTED; // R15

    // Action on a receive timeout
    always_comb begin
        unique case (timeout_exit_select)
            TO_RELAUNCH: timeout_target = ST_RELAUNCH; // R7
            TO_TRANSMIT: timeout_target = ST_TRANSMIT; // R7
            TO_LOWPWR: timeout_target = low_power_choice; // R7
            default: timeout_target = ST_HALTED; // R7
        endcase
    end

    // Next sequencer state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_HALTED: begin
                if (start_req) begin
                    state_nxt = ST_RECEIVE;
                end
            end
            ST_RECEIVE: begin
                if (timeout_ev) begin
                    state_nxt = timeout_target; // R8
                end else begin
                    unique case (receive_exit_select)
                        RX_PAYLOAD_STORE: begin
                            if (i_ev.payload_complete_flag) begin
                                if (checksum_enable && !checksum_fail_autoflush
                                    && i_ev.checksum_bad) begin
                                    state_nxt = timeout_target; // R6
                                end else begin
                                    state_nxt = ST_PACKET_STORED; // R1
                                end
                            end
                        end
                        RX_PAYLOAD_LOWPWR: begin
                            if (i_ev.payload_complete_flag) begin
                                state_nxt = low_power_choice; // R1
                            end
                        end
                        RX_CHECKSUM_STORE: begin
                            if (i_ev.checksum_good_flag) begin
                                state_nxt = ST_PACKET_STORED; // R2
                            end else if (i_ev.payload_complete_flag) begin
                                state_nxt = timeout_target; // R8
                            end
                        end
                        RX_LEVEL_HALT: begin
                            if (i_ev.signal_level_flag) begin
                                state_nxt = ST_HALTED; // R3
                            end
                        end
                        RX_SYNC_HALT: begin
                            if (i_ev.sync_word_match_flag) begin
                                state_nxt = ST_HALTED; // R4
                            end
                        end
                        RX_PREAMBLE_HALT: begin
                            if (i_ev.preamble_seen_flag) begin
                                state_nxt = ST_HALTED; // R5
                            end
                        end
                        default: ; // R1
                    endcase
                end
            end
            ST_PACKET_STORED: begin
                unique case (packet_stored_exit_select)
                    PS_HALT: state_nxt = ST_HALTED; // R9
                    PS_TX_EMPTY: begin
                        if (i_ev.buffer_empty_flag) begin
                            state_nxt = ST_TRANSMIT; // R9
                        end
                    end
                    PS_LOWPWR: state_nxt = low_power_choice; // R9
                    PS_RX_SYNTH: begin
                        state_nxt = i_freq_changed ? ST_FREQ_SYNTH
                            : ST_RECEIVE; // R10
                    end
                    PS_RX_DIRECT: state_nxt = ST_RECEIVE; // R10
                    default: ;
                endcase
            end
            ST_FREQ_SYNTH: state_nxt = ST_RECEIVE; // R10
            ST_RELAUNCH: state_nxt = ST_RECEIVE; // R7
            ST_TRANSMIT: begin
                if (i_ev.packet_sent) begin
                    state_nxt = low_power_choice; // R15
                end
            end
            ST_IDLE: begin
                if (t1_fire) begin
                    state_nxt = idle_exit_select ? ST_RECEIVE
                        : ST_TRANSMIT; // R16
                end
            end
            default: state_nxt = ST_HALTED;
        endcase
    end

    // Sequencer state and its registered outputs
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= ST_HALTED;
            o_state <= ST_HALTED;
            o_relaunch <= 1'b0;
        end else begin
            state_r <= state_nxt;
            o_state <= state_nxt;
            o_relaunch <= (state_nxt == ST_RELAUNCH); // R7
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            status_r <= '0;
        end else begin
            if (bus_done && i_pwrite && addr_ok && idx == IDX_IRQ_STATUS) begin
                status_r <= (status_r & ~i_pwdata[IRQ_W-1:0])
                    | {state_r == ST_RECEIVE && timeout_ev,
                       state_nxt == ST_HALTED && state_r != ST_HALTED,
                       t2_fire, t1_fire};
            end else begin
                status_r <= status_r
                    | {state_r == ST_RECEIVE && timeout_ev,
                       state_nxt == ST_HALTED && state_r != ST_HALTED,
                       t2_fire, t1_fire};
            end
        end
    end

    // Interrupt level from unmasked status
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status_r & mask_r);
        end
    end
endmodule : seq_exit_top

`default_nettype wire

// [sim/seq_exit_chk.sv]
/*
 * Concurrent checks on the ports of seq_exit_top, attached by bind.
 * Assumes seq_exit_pkg is compiled first and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module seq_exit_chk
    import seq_exit_pkg::*;
(
    input wire logic i_sys_clk,       // System clock
    input wire logic i_rstn,          // Async reset, active low
    input wire logic i_psel,          // APB select
    input wire logic i_penable,       // APB enable
    input wire logic [11:0] i_paddr,  // APB byte address
    input wire logic o_pready,        // APB ready
    input wire logic o_pslverr,       // APB error
    input wire rx_events_t i_ev,      // Event pulses
    input wire logic i_freq_changed,  // Frequency changed
    input wire seq_state_t o_state,   // Sequencer state
    input wire logic o_relaunch       // Relaunch pulse
);
    // All checks share the system clock and its reset
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    // Register bus answers after one wait state, for one cycle only
    ready_delay_a: assert property (
        i_psel && $rose(i_penable) |=> o_pready) else $error("ready late");
    ready_pulse_a: assert property (
        o_pready |=> !o_pready) else $error("ready held");
    misalign_err_a: assert property (
        o_pready && i_paddr[1:0] != 2'h0 |-> o_pslverr)
        else $error("misaligned access not refused");

    // Sequencer exits tied to their causes
    stored_entry_a: assert property (
        o_state == ST_PACKET_STORED && $past(o_state) == ST_RECEIVE
        |-> $past(i_ev.payload_complete_flag) ||
            $past(i_ev.checksum_good_flag)) else $error("store uncaused");
    halt_cause_a: assert property (
        o_state == ST_HALTED && $past(o_state) == ST_RECEIVE
        |-> $past(i_ev) != '0) else $error("halt uncaused");
    relaunch_once_a: assert property (
        o_state == ST_RELAUNCH |=> o_state == ST_RECEIVE)
        else $error("relaunch not one cycle");
    relaunch_src_a: assert property (
        $rose(o_relaunch) |-> $past(o_state) == ST_RECEIVE)
        else $error("relaunch from wrong state");
    synth_src_a: assert property (
        o_state == ST_FREQ_SYNTH && $past(o_state) != ST_FREQ_SYNTH
        |-> $past(o_state) == ST_PACKET_STORED && $past(i_freq_changed))
        else $error("synthesis entered wrongly");
    tx_entry_a: assert property (
        o_state == ST_TRANSMIT && $past(o_state) == ST_PACKET_STORED
        |-> $past(i_ev.buffer_empty_flag)) else $error("tx before empty");
    idle_exit_a: assert property (
        $past(o_state) == ST_IDLE && o_state != ST_IDLE
        |-> o_state inside {ST_TRANSMIT, ST_RECEIVE})
        else $error("bad idle exit");
endmodule : seq_exit_chk

bind seq_exit_top seq_exit_chk seq_exit_chk_inst (.i_sys_clk, .i_rstn,
    .i_psel, .i_penable, .i_paddr, .o_pready, .o_pslverr, .i_ev,
    .i_freq_changed, .o_state, .o_relaunch);
`default_nettype wire

// [sim/radio_sequencer_rx_exit_timers_test.sv]
/*
 * Self-checking bench for seq_exit_top: registers over APB, sequencer
 * exits and both interval timers.
 * Assumes package, design and checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value %s expected %0h seen %0h", \
    nm, e, g); end end
module radio_sequencer_rx_exit_timers_test;
    import seq_exit_pkg::*;
    typedef struct packed {
        logic [7:0] cfg;
        logic [3:0] ctl;
        logic fc;
        logic [10:0] e1;
        logic [2:0] s1;
        logic [2:0] s2;
    } row_t;
    logic i_sys_clk, i_rstn, i_psel, i_penable, i_pwrite, i_freq_changed;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic o_pready, o_pslverr, o_relaunch, o_irq, er;
    rx_events_t i_ev;
    seq_state_t o_state;
    int n_checks = 0, miscompares = 0, n = 0;
    // Exit config, control, freq change, event, state after, state later
    row_t rows [18] = '{
        '{8'h20, 4'h0, 1'b0, 11'h400, 3'h3, 3'h0},
        '{8'h40, 4'h0, 1'b0, 11'h400, 3'h0, 3'h0},
        '{8'h40, 4'h1, 1'b0, 11'h400, 3'h7, 3'h7},
        '{8'h61, 4'h0, 1'b0, 11'h200, 3'h3, 3'h6},
        '{8'h80, 4'h0, 1'b0, 11'h080, 3'h0, 3'h0},
        '{8'ha0, 4'h0, 1'b0, 11'h040, 3'h0, 3'h0},
        '{8'hc0, 4'h0, 1'b0, 11'h020, 3'h0, 3'h0},
        '{8'h00, 4'h0, 1'b0, 11'h400, 3'h1, 3'h1},
        '{8'he0, 4'h0, 1'b0, 11'h400, 3'h1, 3'h1},
        '{8'h20, 4'h0, 1'b0, 11'h010, 3'h5, 3'h1},
        '{8'h28, 4'h0, 1'b0, 11'h008, 3'h6, 3'h6},
        '{8'h30, 4'h1, 1'b0, 11'h004, 3'h7, 3'h7},
        '{8'h38, 4'h0, 1'b0, 11'h010, 3'h0, 3'h0},
        '{8'h20, 4'h4, 1'b0, 11'h500, 3'h5, 3'h1},
        '{8'h78, 4'h0, 1'b0, 11'h400, 3'h0, 3'h0},
        '{8'h23, 4'h0, 1'b1, 11'h400, 3'h3, 3'h1},
        '{8'h24, 4'h0, 1'b0, 11'h400, 3'h3, 3'h1},
        '{8'h22, 4'h1, 1'b0, 11'h400, 3'h3, 3'h7}};

    // Short timer ticks keep the run brief
    seq_exit_top #(.FINE_CYC(4), .MID_CYC(8), .COARSE_CYC(16))
        seq_exit_top_inst (.i_sys_clk, .i_rstn, .i_psel, .i_penable,
        .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_ev, .i_freq_changed, .o_state, .o_relaunch, .o_irq);

    // Clock generator
    always #5 i_sys_clk = ~i_sys_clk;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic reset_dut();
        @(posedge i_sys_clk);
        i_rstn <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
    endtask : reset_dut

    // One APB transfer; request held until ready is seen
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] d, input logic [1:0] lo = 2'h0);
        int k = 0;
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= {2'h0, idx, lo};
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 20);
        if (k >= 20) miscompares++;
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        `CHK("read data", e, rd)
    endtask : rdchk

    // One-cycle event pulse, returns where the new state is settled
    task automatic pulse(input logic [10:0] e);
        @(posedge i_sys_clk);
        i_ev <= rx_events_t'(e);
        @(posedge i_sys_clk);
        i_ev <= '0;
        @(negedge i_sys_clk);
    endtask : pulse

    task automatic wait_state(input logic [2:0] s);
        n = 0;
        while (o_state !== s && n < 8) begin
            @(negedge i_sys_clk);
            n++;
        end
    endtask : wait_state

    task automatic wait_irq();
        n = 0;
        while (o_irq !== 1'b1 && n < 600) begin
            @(negedge i_sys_clk);
            n++;
        end
    endtask : wait_irq

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        miscompares++;
        complete_run();
    end

    // Main sequence
    initial begin
        {i_sys_clk, i_rstn, i_psel, i_penable, i_pwrite} = 5'h0;
        {i_paddr, i_pwdata, i_freq_changed} = '0;
        i_ev = '0;
        foreach (rows[k]) begin
            reset_dut();
            i_freq_changed <= rows[k].fc;
            apb(1'b1, IDX_EXIT_CFG, {24'h0, rows[k].cfg});
            apb(1'b1, IDX_CONTROL, {27'h0, 1'b1, rows[k].ctl});
            pulse(rows[k].e1);
            `CHK("first exit", rows[k].s1, o_state)
            `CHK("relaunch", rows[k].s1 == 3'h5, o_relaunch)
            pulse(11'h002);
            wait_state(rows[k].s2);
            `CHK("later state", rows[k].s2, o_state)
        end
        reset_dut();
        rdchk(IDX_EXIT_CFG, 32'h0);
        rdchk(IDX_TICK_SEL, 32'h0);
        rdchk(IDX_T1_MULT, 32'hf5);
        rdchk(IDX_T2_MULT, 32'h20);
        apb(1'b1, IDX_T1_MULT, 32'h5a);
        apb(1'b1, IDX_T2_MULT, 32'ha5);
        apb(1'b1, IDX_TICK_SEL, 32'hff);
        apb(1'b1, IDX_EXIT_CFG, 32'hff);
        rdchk(IDX_T1_MULT, 32'h5a);
        rdchk(IDX_T2_MULT, 32'ha5);
        rdchk(IDX_TICK_SEL, 32'h0f);
        rdchk(IDX_EXIT_CFG, 32'hff);
        apb(1'b0, 8'h50, 32'h0);
        `CHK("unmapped error", 1'b1, er)
        apb(1'b0, IDX_T1_MULT, 32'h0, 2'h1);
        `CHK("misaligned error", 1'b1, er)
        // Idle wake-up by the first timer, then the second timer alone
        reset_dut();
        apb(1'b1, IDX_IRQ_MASK, 32'h3);
        apb(1'b1, IDX_T1_MULT, 32'h3);
        apb(1'b1, IDX_EXIT_CFG, 32'h40);
        apb(1'b1, IDX_CONTROL, 32'h13);
        pulse(11'h400);
        `CHK("idle entry", ST_IDLE, o_state)
        apb(1'b1, IDX_TICK_SEL, 32'h4);
        wait_irq();
        `CHK("first period", 1'b1, n >= 12 && n <= 16)
        `CHK("idle exit", ST_RECEIVE, o_state)
        apb(1'b1, IDX_TICK_SEL, 32'h0);
        apb(1'b1, IDX_IRQ_STATUS, 32'hf);
        repeat (40) @(posedge i_sys_clk);
        rdchk(IDX_IRQ_STATUS, 32'h0);
        `CHK("quiet irq", 1'b0, o_irq)
        apb(1'b1, IDX_TICK_SEL, 32'h3);
        wait_irq();
        `CHK("second period", 1'b1, n >= 512 && n <= 516)
        rdchk(IDX_IRQ_STATUS, 32'h2);
        apb(1'b1, IDX_IRQ_MASK, 32'h1);
        repeat (2) @(negedge i_sys_clk);
        `CHK("masked irq", 1'b0, o_irq)
        complete_run();
    end
endmodule : radio_sequencer_rx_exit_timers_test
`default_nettype wire
